/* rtl/pgc_pkg.sv */
// package: code points, buffer sizes and reset values for the code-group port
package pgc_pkg;

   // ------------------------------------------------------------
   // special code groups (octet form)
   // ------------------------------------------------------------
   localparam logic [7:0] K28_5   = 8'hBC;  // comma, first octet of every idle
   localparam logic [7:0] K27_7_S = 8'hFB;  // start of packet
   localparam logic [7:0] K29_7_T = 8'hFD;  // end of packet
   localparam logic [7:0] K23_7_R = 8'hF7;  // carrier extend
   localparam logic [7:0] K30_7_V = 8'hFE;  // error propagation
   localparam logic [7:0] D5_6_I1 = 8'hC5;  // second octet of /I1/
   localparam logic [7:0] D16_2_I2 = 8'h50; // second octet of /I2/

   // ------------------------------------------------------------
   // gmii values produced from special code groups
   // ------------------------------------------------------------
   localparam logic [7:0] GMII_PREAMBLE = 8'h55;
   localparam logic [7:0] GMII_EXTEND   = 8'h0F;
   localparam logic [7:0] GMII_ERROR    = 8'h1F;

   // ------------------------------------------------------------
   // receive word layout {valid, error, octet}
   // ------------------------------------------------------------
   localparam int RXW_W      = 10;
   localparam int RXW_DV_BIT = 9;
   localparam int RXW_ER_BIT = 8;

   // ------------------------------------------------------------
   // crossing fifo and buffer sizes
   // ------------------------------------------------------------
   localparam int AF_AW       = 2;   // four-entry async fifo
   localparam int AF_DEPTH    = 4;
   localparam int SKID_DEPTH  = 2;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [9:0] ENC_RESET_WORD = 10'h0FA; // K28.5 at negative disparity
   localparam logic       RD_RESET       = 1'b0;    // running disparity negative

   typedef enum logic [1:0] {TS_IDLE, TS_DATA, TS_END, TS_EXT} pgc_tx_state_t;

endpackage : pgc_pkg

/* rtl/pgc_skid.sv */
// two-entry buffer with valid and ready on both sides
module pgc_skid #(
   parameter int W = 10
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst_b,
   input  wire logic         i_valid,
   output logic              o_ready,
   input  wire logic [W-1:0] i_data,
   output logic              o_valid,
   input  wire logic         i_ready,
   output logic [W-1:0]      o_data
);

   logic [W-1:0] mem_q [pgc_pkg::SKID_DEPTH];
   logic         wr_q;
   logic         wr_d;
   logic         rd_q;
   logic         rd_d;
   logic [1:0]   cnt_q;
   logic [1:0]   cnt_d;
   logic         push;
   logic         pop;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      o_ready = (cnt_q != 2'h2);
      o_valid = (cnt_q != 2'h0);
      push    = i_valid & o_ready;
      pop     = o_valid & i_ready;
      wr_d    = push ? ~wr_q : wr_q;
      rd_d    = pop ? ~rd_q : rd_q;
      cnt_d   = cnt_q + {1'b0, push} - {1'b0, pop};
      if (!i_rst_b)
      begin
         wr_d  = 1'b0;
         rd_d  = 1'b0;
         cnt_d = 2'h0;
      end
   end

   always_ff @(posedge i_clk)
   begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
      if (push)
      begin
         mem_q[wr_q] <= i_data;
      end
   end

   assign o_data = mem_q[rd_q];

endmodule : pgc_skid

/* rtl/pgc_port.sv */
// gigabit pcs port: gmii receive outputs and 8-bit code-group link
// ------------------------------------------------------------
// Functional notes
// - rx_dv is high exactly while the octet on the gmii receive data is valid.
// - rx_er is high for errored octets and for carrier extension on the receive data.
// - col is high whenever tx_en and our rx_dv are both high in a cycle, else low.
// - crs follows rx_dv.
// - an 8-bit transmit code group leaves the transmit state machine every cycle.
// - in the 8-bit variant the transmit control flag is 1 for a control character and 0 for data.
// - in the 10-bit variant the first idle of a gap is /I1/ when select is 1 and disparity is positive, else /I2/; the 8-bit variant always sends /I2/.
// - in the 8-bit variant the two flags steer an encoder that sits in the serdes.
// - in the 10-bit variant encoding is done here and the flags carry code bits 8 and 9.
// - received code groups are sampled on the rising edge of the recovered clock.
// ------------------------------------------------------------
module pgc_port #(
   parameter bit P_TEN_BIT = 1'b0
) (
   input  wire logic       i_ref_clk,
   input  wire logic       i_rst_b,
   input  wire logic       i_recovered_rx_clock,
   input  wire logic [7:0] i_tx_d,
   input  wire logic       i_tx_en,
   input  wire logic       i_tx_er,
   input  wire logic       i_idle_disp_sel,
   output logic [7:0]      o_tx_data,
   output logic            o_tx_kcntl,
   output logic            o_tx_disp_cntl,
   input  wire logic [7:0] i_rx_data,
   input  wire logic       i_rx_kcntl,
   output logic [7:0]      o_rx_d,
   output logic            o_rx_dv,
   output logic            o_rx_er,
   output logic            o_col,
   output logic            o_crs,
   input  wire logic       i_rx_ready
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [2:0] bin2gray(input logic [2:0] b);
      bin2gray = b ^ (b >> 1);
   endfunction : bin2gray

   // 5b/6b, negative disparity column, abcdei with a in bit 5
   function automatic logic [5:0] enc6(input logic [4:0] x);
      case (x)
         5'h00: enc6 = 6'h27;
         5'h01: enc6 = 6'h1D;
         5'h02: enc6 = 6'h2D;
         5'h03: enc6 = 6'h31;
         5'h04: enc6 = 6'h35;
         5'h05: enc6 = 6'h29;
         5'h06: enc6 = 6'h19;
         5'h07: enc6 = 6'h38;
         5'h08: enc6 = 6'h39;
         5'h09: enc6 = 6'h25;
         5'h0A: enc6 = 6'h15;
         5'h0B: enc6 = 6'h34;
         5'h0C: enc6 = 6'h0D;
         5'h0D: enc6 = 6'h2C;
         5'h0E: enc6 = 6'h1C;
         5'h0F: enc6 = 6'h17;
         5'h10: enc6 = 6'h1B;
         5'h11: enc6 = 6'h23;
         5'h12: enc6 = 6'h13;
         5'h13: enc6 = 6'h32;
         5'h14: enc6 = 6'h0B;
         5'h15: enc6 = 6'h2A;
         5'h16: enc6 = 6'h1A;
         5'h17: enc6 = 6'h3A;
         5'h18: enc6 = 6'h33;
         5'h19: enc6 = 6'h26;
         5'h1A: enc6 = 6'h16;
         5'h1B: enc6 = 6'h36;
         5'h1C: enc6 = 6'h0E;
         5'h1D: enc6 = 6'h2E;
         5'h1E: enc6 = 6'h1E;
         default: enc6 = 6'h2B;
      endcase
   endfunction : enc6

   // 3b/4b, negative disparity column, fghj with f in bit 3
   function automatic logic [3:0] enc4(input logic [2:0] y);
      case (y)
         3'h0: enc4 = 4'hB;
         3'h1: enc4 = 4'h9;
         3'h2: enc4 = 4'h5;
         3'h3: enc4 = 4'hC;
         3'h4: enc4 = 4'hD;
         3'h5: enc4 = 4'hA;
         3'h6: enc4 = 4'h6;
         default: enc4 = 4'hE;
      endcase
   endfunction : enc4

   // ------------------------------------------------------------
   // link domain: reset synchroniser and code-group capture
   // ------------------------------------------------------------
   logic       lrst_meta_q;
   logic       lrst_b_q;
   logic [7:0] rxd_q;
   logic       rxk_q;
   logic       in_frame_q;
   logic       in_frame_d;
   logic       wr_en;
   logic [9:0] wr_word;
   logic [9:0] af_mem_q [pgc_pkg::AF_DEPTH];
   logic [2:0] wbin_q;
   logic [2:0] wbin_d;
   logic [2:0] wgray_q;
   logic [2:0] rgray_q;
   logic [2:0] rgray_meta_q;
   logic [2:0] rgray_sync_q;
   logic       af_full;

   always_ff @(posedge i_recovered_rx_clock)
   begin
      lrst_meta_q <= i_rst_b;
      lrst_b_q    <= lrst_meta_q;
      rxd_q       <= i_rx_data;
      rxk_q       <= i_rx_kcntl;
   end

   // turn code groups into gmii words; only frame, error and carrier-extend octets are queued
   always_comb
   begin
      in_frame_d = in_frame_q;
      wr_en      = 1'b0;
      wr_word    = {1'b0, 1'b0, rxd_q};
      if (!rxk_q)
      begin
         wr_en   = in_frame_q;
         wr_word = {1'b1, 1'b0, rxd_q};
      end
      else if (rxd_q == pgc_pkg::K27_7_S)
      begin
         in_frame_d = 1'b1;
         wr_en      = 1'b1;
         wr_word    = {1'b1, 1'b0, pgc_pkg::GMII_PREAMBLE};
      end
      else if (rxd_q == pgc_pkg::K29_7_T)
      begin
         in_frame_d = 1'b0;
      end
      else if (rxd_q == pgc_pkg::K23_7_R)
      begin
         in_frame_d = 1'b0;
         wr_en      = 1'b1;
         wr_word    = {1'b0, 1'b1, pgc_pkg::GMII_EXTEND};
      end
      else if (in_frame_q)
      begin
         // any other control inside a frame, /V/ included, is an errored octet
         in_frame_d = (rxd_q != pgc_pkg::K28_5);
         wr_en      = 1'b1;
         wr_word    = {1'b1, 1'b1, pgc_pkg::GMII_ERROR};
      end
      wbin_d = (wr_en && !af_full) ? wbin_q + 3'h1 : wbin_q;
      if (!lrst_b_q)
      begin
         in_frame_d = 1'b0;
         wbin_d     = 3'h0;
      end
   end

   // a full fifo drops the octet: the serdes cannot be stalled
   always_ff @(posedge i_recovered_rx_clock)
   begin
      in_frame_q   <= in_frame_d;
      wbin_q       <= wbin_d;
      wgray_q      <= bin2gray(wbin_d);
      rgray_meta_q <= rgray_q;
      rgray_sync_q <= rgray_meta_q;
      if (wr_en && !af_full && lrst_b_q)
      begin
         af_mem_q[wbin_q[pgc_pkg::AF_AW-1:0]] <= wr_word;
      end
   end

   assign af_full = (wgray_q == {~rgray_sync_q[2:1], rgray_sync_q[0]});

   // ------------------------------------------------------------
   // reference domain: fifo read side feeding the two-entry buffer
   // ------------------------------------------------------------
   logic [2:0] rbin_q;
   logic [2:0] rbin_d;
   logic [2:0] wgray_meta_q;
   logic [2:0] wgray_sync_q;
   logic       af_empty;
   logic       skid_in_ready;
   logic       skid_out_valid;
   logic [9:0] skid_out_data;

   assign af_empty = (rgray_q == wgray_sync_q);

   always_comb
   begin
      rbin_d = (!af_empty && skid_in_ready) ? rbin_q + 3'h1 : rbin_q;
      if (!i_rst_b)
      begin
         rbin_d = 3'h0;
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      rbin_q       <= rbin_d;
      rgray_q      <= bin2gray(rbin_d);
      wgray_meta_q <= wgray_q;
      wgray_sync_q <= wgray_meta_q;
   end

   // buffer ready back-pressures the fifo, which fills toward the link
   pgc_skid #(
      .W (pgc_pkg::RXW_W)
   ) u_skid (
      .i_clk   (i_ref_clk),
      .i_rst_b (i_rst_b),
      .i_valid (!af_empty),
      .o_ready (skid_in_ready),
      .i_data  (af_mem_q[rbin_q[pgc_pkg::AF_AW-1:0]]),
      .o_valid (skid_out_valid),
      .i_ready (i_rx_ready),
      .o_data  (skid_out_data)
   );

   // ------------------------------------------------------------
   // gmii receive outputs
   // ------------------------------------------------------------
   assign o_rx_d  = skid_out_data[7:0];
   assign o_rx_dv = skid_out_valid & skid_out_data[pgc_pkg::RXW_DV_BIT];
   assign o_rx_er = skid_out_valid & skid_out_data[pgc_pkg::RXW_ER_BIT];
   assign o_col   = i_tx_en & o_rx_dv;
   assign o_crs   = o_rx_dv;

   // ------------------------------------------------------------
   // transmit state machine
   // ------------------------------------------------------------
   pgc_pkg::pgc_tx_state_t ts_q;
   pgc_pkg::pgc_tx_state_t ts_d;
   logic       odd_q;
   logic       odd_d;
   logic       first_idle_q;
   logic       first_idle_d;
   logic [7:0] ch;
   logic       ch_k;
   logic       disp_sel;
   logic       rd_q;
   logic       rd_d;

   // idles start only on even slots so the comma keeps its alignment
   always_comb
   begin
      ts_d         = ts_q;
      odd_d        = ~odd_q;
      first_idle_d = first_idle_q;
      ch           = pgc_pkg::K28_5;
      ch_k         = 1'b1;
      disp_sel     = 1'b0;
      case (ts_q)
         pgc_pkg::TS_IDLE:
         begin
            if (!odd_q && i_tx_en)
            begin
               ch   = pgc_pkg::K27_7_S;
               ts_d = pgc_pkg::TS_DATA;
            end
            else if (odd_q)
            begin
               ch_k         = 1'b0;
               disp_sel     = first_idle_q & i_idle_disp_sel;
               ch           = (disp_sel && P_TEN_BIT && rd_q) ?
                              pgc_pkg::D5_6_I1 : pgc_pkg::D16_2_I2;
               first_idle_d = 1'b0;
            end
         end
         pgc_pkg::TS_DATA:
         begin
            if (i_tx_en)
            begin
               ch   = i_tx_er ? pgc_pkg::K30_7_V : i_tx_d;
               ch_k = i_tx_er;
            end
            else
            begin
               ch   = pgc_pkg::K29_7_T;
               ts_d = pgc_pkg::TS_END;
            end
         end
         pgc_pkg::TS_END:
         begin
            ch   = pgc_pkg::K23_7_R;
            ts_d = (i_tx_er || !odd_q) ? pgc_pkg::TS_EXT : pgc_pkg::TS_IDLE;
            // an odd slot after /T/R/ is padded by one more /R/
            first_idle_d = 1'b1;
         end
         pgc_pkg::TS_EXT:
         begin
            ch   = pgc_pkg::K23_7_R;
            ts_d = ((!i_tx_en && i_tx_er) || !odd_q) ? pgc_pkg::TS_EXT : pgc_pkg::TS_IDLE;
         end
         default:
         begin
            ts_d = pgc_pkg::TS_IDLE;
         end
      endcase
      if (!i_rst_b)
      begin
         ts_d         = pgc_pkg::TS_IDLE;
         odd_d        = 1'b0;
         first_idle_d = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // optional 8b/10b encoder and output register
   // ------------------------------------------------------------
   logic [5:0] c6;
   logic [3:0] c4;
   logic       rd_mid;
   logic       alt7;
   logic [7:0] tx_data_d;
   logic       tx_k_d;
   logic       tx_disp_d;
   logic [7:0] tx_data_q;
   logic       tx_k_q;
   logic       tx_disp_q;

   always_comb
   begin
      c6 = (ch_k && ch[4:0] == 5'h1C) ? 6'h0F : enc6(ch[4:0]);
      if (rd_q && (c6 == 6'h38 || (c6 != 6'h0F && c6[5] + c6[4] + c6[3] + c6[2] + c6[1] + c6[0] != 3'h3)
          || c6 == 6'h0F))
      begin
         c6 = ~c6;
      end
      rd_mid = (c6[5] + c6[4] + c6[3] + c6[2] + c6[1] + c6[0] == 3'h3) ? rd_q : ~rd_q;
      alt7   = ch_k || (!rd_mid && (ch[4:0] == 5'h11 || ch[4:0] == 5'h12 || ch[4:0] == 5'h14))
               || (rd_mid && (ch[4:0] == 5'h0B || ch[4:0] == 5'h0D || ch[4:0] == 5'h0E));
      c4 = (ch[7:5] == 3'h7 && alt7) ? 4'h7 : enc4(ch[7:5]);
      if ((rd_mid && (c4[3] + c4[2] + c4[1] + c4[0] != 3'h2 || ch[7:5] == 3'h3))
          || (ch_k && ch[4:0] == 5'h1C && !rd_mid && c4[3] + c4[2] + c4[1] + c4[0] == 3'h2))
      begin
         c4 = ~c4;
      end
      rd_d = (c4[3] + c4[2] + c4[1] + c4[0] == 3'h2) ? rd_mid : ~rd_mid;
      if (P_TEN_BIT)
      begin
         // flags carry the two top code bits
         {tx_disp_d, tx_k_d, tx_data_d} = {c6, c4};
      end
      else
      begin
         tx_data_d = ch;
         tx_k_d    = ch_k;
         tx_disp_d = disp_sel;
      end
      if (!i_rst_b)
      begin
         rd_d = pgc_pkg::RD_RESET;
         if (P_TEN_BIT)
         begin
            {tx_disp_d, tx_k_d, tx_data_d} = pgc_pkg::ENC_RESET_WORD;
         end
         else
         begin
            tx_data_d = pgc_pkg::K28_5;
            tx_k_d    = 1'b1;
            tx_disp_d = 1'b0;
         end
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      ts_q         <= ts_d;
      odd_q        <= odd_d;
      first_idle_q <= first_idle_d;
      rd_q         <= rd_d;
      tx_data_q    <= tx_data_d;
      tx_k_q       <= tx_k_d;
      tx_disp_q    <= tx_disp_d;
   end

   assign o_tx_data      = tx_data_q;
   assign o_tx_kcntl     = tx_k_q;
   assign o_tx_disp_cntl = tx_disp_q;

endmodule : pgc_port

/* verif/pgc_port_assertions.sv */
// checker: port-level assertions for the code-group port
module pgc_port_assertions #(
   parameter bit P_TEN_BIT = 1'b0
) (
   input wire logic       i_ref_clk,
   input wire logic       i_rst_b,
   input wire logic       i_recovered_rx_clock,
   input wire logic [7:0] i_tx_d,
   input wire logic       i_tx_en,
   input wire logic       i_tx_er,
   input wire logic       i_idle_disp_sel,
   input wire logic [7:0] o_tx_data,
   input wire logic       o_tx_kcntl,
   input wire logic       o_tx_disp_cntl,
   input wire logic [7:0] i_rx_data,
   input wire logic       i_rx_kcntl,
   input wire logic [7:0] o_rx_d,
   input wire logic       o_rx_dv,
   input wire logic       o_rx_er,
   input wire logic       o_col,
   input wire logic       o_crs,
   input wire logic       i_rx_ready
);
   // ------------------------------------------------------------
   // reset word and common relations
   // ------------------------------------------------------------
   localparam logic [9:0] RESET_WORD = P_TEN_BIT ? pgc_pkg::ENC_RESET_WORD : {2'b01, pgc_pkg::K28_5};
   default clocking cb @(posedge i_ref_clk);
   endclocking

   a_col_tx_rx: assert property (disable iff (!i_rst_b) o_col == (i_tx_en && o_rx_dv))
      else $error("collision differs from tx_en and rx_dv");
   a_crs_follows_dv: assert property (disable iff (!i_rst_b) o_crs == o_rx_dv)
      else $error("carrier sense differs from rx_dv");
   a_reset_gmii_quiet: assert property (!i_rst_b |=> !o_rx_dv && !o_rx_er && !o_col && !o_crs)
      else $error("gmii outputs active during reset");
   a_reset_tx_idle: assert property (!i_rst_b |=> {o_tx_disp_cntl, o_tx_kcntl, o_tx_data} == RESET_WORD)
      else $error("transmit output not idle during reset");
   // a held word must not change or vanish before the receiver takes it
   a_rx_word_stands: assert property (disable iff (!i_rst_b) (o_rx_dv || o_rx_er) && !i_rx_ready
      |=> $stable({o_rx_dv, o_rx_er, o_rx_d})) else $error("receive word changed before pop");

   // ------------------------------------------------------------
   // transmit framing, 8-bit variant only
   // ------------------------------------------------------------
   if (!P_TEN_BIT) begin : g_eight
      sequence s_ext_end;
         (o_tx_kcntl && o_tx_data == pgc_pkg::K23_7_R) ##1 (o_tx_data == pgc_pkg::K28_5);
      endsequence
      sequence s_first_idle;
         !o_tx_kcntl && o_tx_data == pgc_pkg::D16_2_I2 && o_tx_disp_cntl == i_idle_disp_sel;
      endsequence
      a_frame_start: assert property (disable iff (!i_rst_b) $rose(i_tx_en)
         |-> ##[1:3] (o_tx_kcntl && o_tx_data == pgc_pkg::K27_7_S)) else $error("no start code after tx_en");
      a_frame_end: assert property (disable iff (!i_rst_b) $fell(i_tx_en)
         |-> ##1 (o_tx_kcntl && o_tx_data == pgc_pkg::K29_7_T)) else $error("no end code after tx_en fell");
      a_idle_pair: assert property (disable iff (!i_rst_b) i_rst_b && $past(i_rst_b) && o_tx_kcntl
         && o_tx_data == pgc_pkg::K28_5 |=> !o_tx_kcntl && o_tx_data == pgc_pkg::D16_2_I2)
         else $error("comma not followed by idle data octet");
      a_gap_disp_sel: assert property (disable iff (!i_rst_b) s_ext_end |=> s_first_idle)
         else $error("first idle of gap has wrong disparity flag");
   end
endmodule : pgc_port_assertions

bind pgc_port pgc_port_assertions #(.P_TEN_BIT(P_TEN_BIT)) u_pgc_port_assertions (
   .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_recovered_rx_clock(i_recovered_rx_clock),
   .i_tx_d(i_tx_d), .i_tx_en(i_tx_en), .i_tx_er(i_tx_er), .i_idle_disp_sel(i_idle_disp_sel),
   .o_tx_data(o_tx_data), .o_tx_kcntl(o_tx_kcntl), .o_tx_disp_cntl(o_tx_disp_cntl),
   .i_rx_data(i_rx_data), .i_rx_kcntl(i_rx_kcntl), .o_rx_d(o_rx_d), .o_rx_dv(o_rx_dv),
   .o_rx_er(o_rx_er), .o_col(o_col), .o_crs(o_crs), .i_rx_ready(i_rx_ready));

/* verif/pgc_serdes_model.sv */
// serdes receive-side model: code groups and control flag on the recovered clock
module pgc_serdes_model (
   input  wire logic  i_clk,
   output logic [7:0] o_rx_data,
   output logic       o_rx_kcntl
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [8:0] pend_q[$];
   logic       odd;
   logic [8:0] cg;

   initial
   begin
      o_rx_data  = pgc_pkg::K28_5;
      o_rx_kcntl = 1'b1;
      odd        = 1'b0;
   end

   // new group just after each rising edge, so the port captures it at the next one
   always @(posedge i_clk)
   begin
      #1;
      if (pend_q.size() > 0)
         cg = pend_q.pop_front();
      else
         cg = odd ? {1'b0, pgc_pkg::D16_2_I2} : {1'b1, pgc_pkg::K28_5};
      odd        = ~odd;
      o_rx_kcntl = cg[8];
      o_rx_data  = cg[7:0];
   end

   task automatic send(input logic k, input logic [7:0] d);
      pend_q.push_back({k, d});
   endtask : send
endmodule : pgc_serdes_model

/* verif/tb.sv */
// testbench: transmit framing, receive path, stall and collision of the code-group port
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic       ref_clk, rst_b, link_clk, tx_en, tx_er, idle_sel, tx_k, tx_disp;
   logic       rx_k, rx_dv, rx_er, col, crs, rx_ready, tx10_k, tx10_disp;
   logic [7:0] tx_d, tx_data, rx_data, rx_d, tx10_data;
   logic [9:0] rxq[$];
   int         errors;
   int         samples_checked;

   initial
   begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   initial
   begin
      link_clk = 1'b0;
      #7;
      forever #32 link_clk = ~link_clk;
   end

   pgc_port #(.P_TEN_BIT(1'b0)) u_pgc_port (
      .i_ref_clk(ref_clk), .i_rst_b(rst_b), .i_recovered_rx_clock(link_clk), .i_tx_d(tx_d),
      .i_tx_en(tx_en), .i_tx_er(tx_er), .i_idle_disp_sel(idle_sel), .o_tx_data(tx_data),
      .o_tx_kcntl(tx_k), .o_tx_disp_cntl(tx_disp), .i_rx_data(rx_data), .i_rx_kcntl(rx_k),
      .o_rx_d(rx_d), .o_rx_dv(rx_dv), .o_rx_er(rx_er), .o_col(col), .o_crs(crs), .i_rx_ready(rx_ready));
   pgc_serdes_model u_pgc_serdes_model (.i_clk(link_clk), .o_rx_data(rx_data), .o_rx_kcntl(rx_k));
   // second copy in the 10-bit variant, fed the same stimulus
   pgc_port #(.P_TEN_BIT(1'b1)) u_pgc_port_ten (
      .i_ref_clk(ref_clk), .i_rst_b(rst_b), .i_recovered_rx_clock(link_clk), .i_tx_d(tx_d),
      .i_tx_en(tx_en), .i_tx_er(tx_er), .i_idle_disp_sel(idle_sel), .o_tx_data(tx10_data),
      .o_tx_kcntl(tx10_k), .o_tx_disp_cntl(tx10_disp), .i_rx_data(rx_data), .i_rx_kcntl(rx_k),
      .o_rx_d(), .o_rx_dv(), .o_rx_er(), .o_col(), .o_crs(), .i_rx_ready(rx_ready));

   // words popped by the receiver, in order
   always @(posedge ref_clk)
      if (rx_ready === 1'b1 && (rx_dv === 1'b1 || rx_er === 1'b1))
         rxq.push_back({rx_dv, rx_er, rx_d});

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic tally_and_finish();
      if (errors == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : tally_and_finish

   task automatic reset_values();
      @(negedge ref_clk);
      check("reset_tx", {tx_disp, tx_k, tx_data}, {2'b01, pgc_pkg::K28_5});
      check("reset_gmii", {rx_dv, rx_er, col, crs}, 4'h0);
      check("reset_ten", {tx10_disp, tx10_k, tx10_data}, pgc_pkg::ENC_RESET_WORD);
   endtask : reset_values

   // 10-bit idles after release: K28.5 at negative disparity, then D16.2 at positive
   task automatic ten_bit_idle();
      @(negedge ref_clk);
      check("ten_k28_5", {tx10_disp, tx10_k, tx10_data}, pgc_pkg::ENC_RESET_WORD);
      @(negedge ref_clk);
      check("ten_d16_2", {tx10_disp, tx10_k, tx10_data}, 10'h245);
      repeat (2) @(negedge ref_clk);
   endtask : ten_bit_idle

   // frame with preamble, four octets, three extension cycles, then a gap
   task automatic tx_frame(input logic sel);
      logic [9:0] q[16];
      int         j;
      idle_sel = sel;
      for (int i = 0; i < 16; i++)
      begin
         @(negedge ref_clk);
         q[i]  = {tx_disp, tx_k, tx_data};
         tx_en = (i < 6);
         tx_er = (i > 5 && i < 9);
         tx_d  = (i < 2) ? pgc_pkg::GMII_PREAMBLE : 8'hA0 + 8'(i);
      end
      j = 0;
      while (j < 15 && q[j] !== {2'b01, pgc_pkg::K27_7_S})
         j++;
      check("tx_sop", q[j], {2'b01, pgc_pkg::K27_7_S});
      j++;
      while (j < 15 && q[j] === {2'b00, pgc_pkg::GMII_PREAMBLE})
         j++;
      for (int k = 2; k < 6; k++)
      begin
         check("tx_octet", q[j], {2'b00, 8'hA0 + 8'(k)});
         j++;
      end
      check("tx_eop", q[j], {2'b01, pgc_pkg::K29_7_T});
      j++;
      check("tx_ext", q[j], {2'b01, pgc_pkg::K23_7_R});
      while (j < 15 && q[j] === {2'b01, pgc_pkg::K23_7_R})
         j++;
      check("tx_idle_k", q[j], {2'b01, pgc_pkg::K28_5});
      check("tx_idle_d", q[j + 1], {sel, 1'b0, pgc_pkg::D16_2_I2});
   endtask : tx_frame

   // start, data, error code, data, end, extension; optionally stalled with a collision
   task automatic rx_frame(input logic stall);
      logic [9:0] exp[5];
      exp = '{10'h255, 10'h211, 10'h31F, 10'h222, 10'h10F};
      rxq.delete();
      rx_ready = !stall;
      u_pgc_serdes_model.send(1'b1, pgc_pkg::K27_7_S);
      u_pgc_serdes_model.send(1'b0, 8'h11);
      u_pgc_serdes_model.send(1'b1, pgc_pkg::K30_7_V);
      u_pgc_serdes_model.send(1'b0, 8'h22);
      u_pgc_serdes_model.send(1'b1, pgc_pkg::K29_7_T);
      u_pgc_serdes_model.send(1'b1, pgc_pkg::K23_7_R);
      if (stall)
      begin
         repeat (60) @(negedge ref_clk);
         check("rx_held", {rx_dv, rx_er, rx_d}, {2'b10, pgc_pkg::GMII_PREAMBLE});
         tx_en = 1'b1;
         #1 check("col_crs", {col, crs}, 2'b11);
         repeat (3) @(negedge ref_clk);
         tx_en    = 1'b0;
         rx_ready = 1'b1;
      end
      repeat (60) @(negedge ref_clk);
      check("rx_count", 16'(rxq.size()), 16'h0005);
      foreach (exp[i])
         check("rx_word", rxq[i], exp[i]);
   endtask : rx_frame

   initial
   begin
      rst_b           = 1'b0;
      tx_d            = 8'h00;
      tx_en           = 1'b0;
      tx_er           = 1'b0;
      idle_sel        = 1'b0;
      rx_ready        = 1'b1;
      errors          = 0;
      samples_checked = 0;
      // longer than eight cycles so the link-side synchroniser sees four edges
      repeat (12) @(negedge ref_clk);
      reset_values();
      rst_b = 1'b1;
      ten_bit_idle();
      tx_frame(1'b1);
      tx_frame(1'b0);
      rx_frame(1'b1);
      rx_frame(1'b0);
      tally_and_finish();
   end

   initial
   begin
      #100000;
      errors++;
      tally_and_finish();
   end
endmodule : tb
